// [design/spmc_pkg.sv]
// Purpose: shared constants for the serdes path and mode controller
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: mode codes select the device path pins through one decoder
package spmc_pkg;

	localparam int unsigned ADDR_W    = 8;
	localparam int unsigned WORD_W    = 4;
	localparam int unsigned PAT_DEPTH = 16;
	localparam int unsigned PAT_AW    = 4;
	localparam int unsigned CNT_W     = 16;

	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_PATWR  = 8'h08;
	localparam logic [7:0] OFF_PATLEN = 8'h0C;

	// control register fields
	localparam int unsigned CTRL_TXEN_BIT  = 0;
	localparam int unsigned CTRL_MODE_LSB  = 1;
	localparam int unsigned CTRL_RATE_LSB  = 5;
	// status register fields
	localparam int unsigned STAT_WORD_LSB  = 0;
	localparam int unsigned STAT_CNT_LSB   = 16;
	// pattern write fields
	localparam int unsigned PATWR_DATA_LSB = 0;
	localparam int unsigned PATWR_IDX_LSB  = 4;

	// rate select order: rx0, rx1, tx0, tx1 in bits 0..3
	localparam logic [3:0] RATE_RESET   = 4'hB;
	localparam logic [3:0] PATLEN_RESET = 4'hF;

	typedef enum logic [2:0] {
		SPMC_NORMAL     = 3'b000,
		SPMC_NORMAL_SEC = 3'b001,
		SPMC_RLB_BASIC  = 3'b010,
		SPMC_RLB_CLK    = 3'b011,
		SPMC_RLB_DATA   = 3'b100,
		SPMC_CDR_BYPASS = 3'b101,
		SPMC_LOCAL_LB   = 3'b110
	} spmc_mode_t;

endpackage

// [design/spmc_pat_mem.sv]
// Purpose: small transmit pattern memory with registered read data
// Assumes: one write port and one read port on the same clock
// Notes: read data appear one clock after the address
`timescale 1ns/1ns
module spmc_pat_mem #(
	parameter int unsigned WIDTH = 4,
	parameter int unsigned DEPTH = 16,
	parameter int unsigned AW    = 4
) (
	input  wire logic             clk_i,    // clock
	input  wire logic             we_i,     // write strobe
	input  wire logic [AW-1:0]    waddr_i,  // write address
	input  wire logic [WIDTH-1:0] wdata_i,  // write data
	input  wire logic [AW-1:0]    raddr_i,  // read address
	output logic      [WIDTH-1:0] rdata_o   // registered read data
);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] rdata_q;

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_q[waddr_i] <= wdata_i;
		end
		rdata_q <= mem_q[raddr_i];
	end

	assign rdata_o = rdata_q;

endmodule

// [design/spmc_ctrl.sv]
// Purpose: host-side controller driving the serdes path, rate and parallel pins
// Assumes: receive words arrive on the device's receive parallel clock
// Notes: transmit parallel clock is divided from ref_clk_i
//
// How it works
// - transmit data aligned to driven parallel clock
// - normal flow: path selects one, double rate zero
// - rate selects reset to one, one, zero, one
// - secondary mode: board routes secondary clock back
// - both transmit path selects zero: basic loopback
// - basic remote loopback never combined with local
// - transmit selects one, zero: recovered clock loopback
// - transmit selects zero, one: recovered data loopback
// - reference clock kept running in loopback modes
// - bypass needs 155.52 MHz reference and rate
`timescale 1ns/1ns
module spmc_ctrl (
	input  wire logic        ref_clk_i,             // system clock, 25 MHz
	input  wire logic        reset_n_i,             // synchronous reset, active low
	input  wire logic [7:0]  paddr_i,               // apb address
	input  wire logic        psel_i,                // apb select
	input  wire logic        penable_i,             // apb enable
	input  wire logic        pwrite_i,              // apb direction
	input  wire logic [31:0] pwdata_i,              // apb write data
	output logic      [31:0] prdata_o,              // apb read data
	output logic             pready_o,              // apb ready
	output logic             pslverr_o,             // apb error
	input  wire logic        rx_par_clk_i,          // device receive parallel clock
	input  wire logic [3:0]  rx_par_data_i,         // device receive parallel word
	output logic             tx_par_clk_o,          // transmit parallel clock to device
	output logic      [3:0]  tx_par_data_o,         // transmit parallel word to device
	output logic             rx_path_sel0_o,        // receive path select 0
	output logic             rx_path_sel1_o,        // receive path select 1
	output logic             tx_path_sel0_o,        // transmit path select 0
	output logic             tx_path_sel1_o,        // transmit path select 1
	output logic             rx_double_rate_sel_o,  // receive double rate select
	output logic             rx_rate_sel0_o,        // receive rate select 0
	output logic             rx_rate_sel1_o,        // receive rate select 1
	output logic             tx_rate_sel0_o,        // transmit rate select 0
	output logic             tx_rate_sel1_o,        // transmit rate select 1
	output logic             ref_osc_en_o,          // reference oscillator enable
	output logic             ref_sel_bypass_o       // pick bypass-rate reference
);

	// register file
	logic                                  txen_q, txen_d;
	spmc_pkg::spmc_mode_t                  mode_q, mode_d;
	logic [3:0]                            rate_q, rate_d;
	logic [spmc_pkg::PAT_AW-1:0]           patlen_q, patlen_d;
	logic                                  pat_we;
	logic [spmc_pkg::PAT_AW-1:0]           pat_waddr;
	logic [spmc_pkg::WORD_W-1:0]           pat_wdata;
	logic                                  acc;
	logic                                  hit;
	logic [spmc_pkg::WORD_W-1:0]           rxw_q, rxw_d;
	logic [spmc_pkg::CNT_W-1:0]            rxcnt_q, rxcnt_d;
	logic [2:0]                            mode_wr;

	assign acc       = psel_i && penable_i;
	assign pready_o  = 1'b1;
	assign hit       = (paddr_i == spmc_pkg::OFF_CTRL)
	                   || (paddr_i == spmc_pkg::OFF_STATUS)
	                   || (paddr_i == spmc_pkg::OFF_PATWR)
	                   || (paddr_i == spmc_pkg::OFF_PATLEN);
	assign pslverr_o = psel_i && penable_i && !hit;
	assign mode_wr   = pwdata_i[spmc_pkg::CTRL_MODE_LSB +: 3];
	// a pattern write carries index and word together in one access
	assign pat_we    = acc && pwrite_i && (paddr_i == spmc_pkg::OFF_PATWR);
	assign pat_waddr = pwdata_i[spmc_pkg::PATWR_IDX_LSB +: spmc_pkg::PAT_AW];
	assign pat_wdata = pwdata_i[spmc_pkg::PATWR_DATA_LSB +: spmc_pkg::WORD_W];

	always_comb begin
		txen_d   = txen_q;
		mode_d   = mode_q;
		rate_d   = rate_q;
		patlen_d = patlen_q;
		if (acc && pwrite_i && (paddr_i == spmc_pkg::OFF_CTRL)) begin
			txen_d = pwdata_i[spmc_pkg::CTRL_TXEN_BIT];
			// codes above the last mode are ignored
			if (mode_wr <= 3'h6) begin
				mode_d = spmc_pkg::spmc_mode_t'(mode_wr);
			end
			rate_d = pwdata_i[spmc_pkg::CTRL_RATE_LSB +: 4];
		end
		if (acc && pwrite_i && (paddr_i == spmc_pkg::OFF_PATLEN)) begin
			patlen_d = pwdata_i[spmc_pkg::PAT_AW-1:0];
		end
	end

	always_comb begin
		// reads have no side effects; the status word is a snapshot
		prdata_o = 32'h0000_0000;
		if (psel_i && !pwrite_i) begin
			unique case (paddr_i)
				spmc_pkg::OFF_CTRL: begin
					prdata_o[spmc_pkg::CTRL_TXEN_BIT]        = txen_q;
					prdata_o[spmc_pkg::CTRL_MODE_LSB +: 3]   = mode_q;
					prdata_o[spmc_pkg::CTRL_RATE_LSB +: 4]   = rate_q;
				end
				spmc_pkg::OFF_STATUS: begin
					prdata_o[spmc_pkg::STAT_WORD_LSB +: spmc_pkg::WORD_W] = rxw_q;
					prdata_o[spmc_pkg::STAT_CNT_LSB +: spmc_pkg::CNT_W]   = rxcnt_q;
				end
				spmc_pkg::OFF_PATLEN: begin
					prdata_o[spmc_pkg::PAT_AW-1:0] = patlen_q;
				end
				default: begin
					prdata_o = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			txen_q   <= 1'b0;
			mode_q   <= spmc_pkg::SPMC_NORMAL;
			rate_q   <= spmc_pkg::RATE_RESET;
			patlen_q <= spmc_pkg::PATLEN_RESET;
		end else begin
			txen_q   <= txen_d;
			mode_q   <= mode_d;
			rate_q   <= rate_d;
			patlen_q <= patlen_d;
		end
	end

	// device pin decode
	// the pins come from flops so a mode write never glitches the device
	logic [4:0] pins_q, pins_d; // rx0, rx1, tx0, tx1, ddr
	logic       reset_n_q;

	always_comb begin
		pins_d = 5'h0F;
		unique case (mode_q)
			spmc_pkg::SPMC_NORMAL:     pins_d = 5'h0F;
			spmc_pkg::SPMC_NORMAL_SEC: pins_d = 5'h0F;
			spmc_pkg::SPMC_RLB_BASIC:  pins_d = 5'h03;
			spmc_pkg::SPMC_RLB_CLK:    pins_d = 5'h07;
			spmc_pkg::SPMC_RLB_DATA:   pins_d = 5'h0B;
			spmc_pkg::SPMC_CDR_BYPASS: pins_d = 5'h0E;
			spmc_pkg::SPMC_LOCAL_LB:   pins_d = 5'h0D;
			default:                   pins_d = 5'h0F;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			pins_q <= 5'h0F;
		end else begin
			pins_q <= pins_d;
		end
	end

	// pins_q bit 0 is rx select 0, bit 4 the double rate select
	assign rx_path_sel0_o       = pins_q[0];
	assign rx_path_sel1_o       = pins_q[1];
	assign tx_path_sel0_o       = pins_q[2];
	assign tx_path_sel1_o       = pins_q[3];
	assign rx_double_rate_sel_o = pins_q[4];
	assign rx_rate_sel0_o       = rate_q[0];
	assign rx_rate_sel1_o       = rate_q[1];
	assign tx_rate_sel0_o       = rate_q[2];
	assign tx_rate_sel1_o       = rate_q[3];
	// the reference stays enabled in every mode; clock recovery needs it
	assign ref_osc_en_o         = reset_n_q;
	assign ref_sel_bypass_o     = (mode_q == spmc_pkg::SPMC_CDR_BYPASS);

	// one clock of delay holds the reference enable low until reset is over
	always_ff @(posedge ref_clk_i) begin
		reset_n_q <= reset_n_i;
	end

	// transmit side
	logic                        tclk_q, tclk_d;
	logic [spmc_pkg::PAT_AW-1:0] idx_q, idx_d;
	logic [spmc_pkg::WORD_W-1:0] txd_q, txd_d;
	logic [spmc_pkg::WORD_W-1:0] pat_rdata;
	logic                        tx_run;

	spmc_pat_mem #(
		.WIDTH (spmc_pkg::WORD_W),
		.DEPTH (spmc_pkg::PAT_DEPTH),
		.AW    (spmc_pkg::PAT_AW)
	) u_pat (
		.clk_i   (ref_clk_i),
		.we_i    (pat_we),
		.waddr_i (pat_waddr),
		.wdata_i (pat_wdata),
		.raddr_i (idx_q),
		.rdata_o (pat_rdata)
	);

	// in secondary mode the board feeds the device's own clock back, so ours stays low
	assign tx_run = txen_q && (mode_q != spmc_pkg::SPMC_NORMAL_SEC);

	// idx moves every second clock, so the registered read is always in time
	always_comb begin
		tclk_d = 1'b0;
		idx_d  = idx_q;
		txd_d  = txd_q;
		if (tx_run) begin
			tclk_d = !tclk_q;
			// data change on the falling edge, device samples on the rising one
			if (tclk_q) begin
				txd_d = pat_rdata;
				idx_d = (idx_q == patlen_q) ? '0 : idx_q + 4'h1;
			end
		end else begin
			idx_d = '0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			tclk_q <= 1'b0;
			idx_q  <= '0;
			txd_q  <= '0;
		end else begin
			tclk_q <= tclk_d;
			idx_q  <= idx_d;
			txd_q  <= txd_d;
		end
	end

	assign tx_par_clk_o  = tclk_q;
	assign tx_par_data_o = txd_q;

	// receive side, link domain
	logic [1:0]                  lrst_q;
	logic [1:0]                  lack_q;
	logic                        lreq_q, lreq_d;
	logic [spmc_pkg::WORD_W-1:0] lword_q, lword_d;
	logic                        ack_q, ack_d;

	// reset and ack both cross into the link domain by two flops
	// rx_par_data_i is launched by rx_par_clk_i, so it needs no synchroniser
	always_ff @(posedge rx_par_clk_i) begin
		lrst_q <= {lrst_q[0], reset_n_i};
		lack_q <= {lack_q[0], ack_q};
	end

	always_comb begin
		lreq_d  = lreq_q;
		lword_d = lword_q;
		// a new word is taken only once the last one was acknowledged
		// lword_q then holds still until the ack returns, so the other side may read it
		if (lreq_q == lack_q[1]) begin
			lword_d = rx_par_data_i;
			lreq_d  = !lreq_q;
		end
	end

	always_ff @(posedge rx_par_clk_i) begin
		if (!lrst_q[1]) begin
			lreq_q  <= 1'b0;
			lword_q <= '0;
		end else begin
			lreq_q  <= lreq_d;
			lword_q <= lword_d;
		end
	end

	// receive side, system domain
	// req comes back by two flops; the word count wraps, so software compares two reads
	logic [1:0] sreq_q;

	always_ff @(posedge ref_clk_i) begin
		sreq_q <= {sreq_q[0], lreq_q};
	end

	always_comb begin
		ack_d   = ack_q;
		rxw_d   = rxw_q;
		rxcnt_d = rxcnt_q;
		if (sreq_q[1] != ack_q) begin
			rxw_d   = lword_q;
			rxcnt_d = rxcnt_q + 16'h0001;
			ack_d   = !ack_q;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			ack_q   <= 1'b0;
			rxw_q   <= '0;
			rxcnt_q <= '0;
		end else begin
			ack_q   <= ack_d;
			rxw_q   <= rxw_d;
			rxcnt_q <= rxcnt_d;
		end
	end

endmodule

// [tb/spmc_chk.sv]
// Purpose: port relations of the serdes controller
// Assumes: one clock domain at the watched ports
// Notes: mode is tracked from control writes
`timescale 1ns/1ns
module spmc_chk (
	input wire logic        ref_clk_i,            // clock
	input wire logic        reset_n_i,            // reset
	input wire logic [7:0]  paddr_i,              // apb
	input wire logic        psel_i,               // apb
	input wire logic        penable_i,            // apb
	input wire logic        pwrite_i,             // apb
	input wire logic [31:0] pwdata_i,             // apb
	input wire logic        tx_par_clk_o,         // tx clock
	input wire logic [3:0]  tx_par_data_o,        // tx word
	input wire logic        rx_path_sel0_o,       // pin
	input wire logic        rx_path_sel1_o,       // pin
	input wire logic        tx_path_sel0_o,       // pin
	input wire logic        tx_path_sel1_o,       // pin
	input wire logic        rx_double_rate_sel_o, // pin
	input wire logic        rx_rate_sel0_o,       // pin
	input wire logic        rx_rate_sel1_o,       // pin
	input wire logic        tx_rate_sel0_o,       // pin
	input wire logic        tx_rate_sel1_o,       // pin
	input wire logic        ref_sel_bypass_o      // pin
);
	logic [2:0] mode_q;
	logic [2:0] mode_d;
	logic       wr;
	logic [4:0] pins;
	logic [3:0] rate;
	assign wr = psel_i && penable_i && pwrite_i && paddr_i == spmc_pkg::OFF_CTRL;
	assign pins = {rx_path_sel0_o, rx_path_sel1_o, tx_path_sel0_o, tx_path_sel1_o,
		rx_double_rate_sel_o};
	assign rate = {tx_rate_sel1_o, tx_rate_sel0_o, rx_rate_sel1_o, rx_rate_sel0_o};
	// code 7 is refused, so the tracked mode keeps its value
	always_comb begin
		mode_d = mode_q;
		if (wr && pwdata_i[3:1] != 3'h7) begin
			mode_d = pwdata_i[3:1];
		end
	end
	always_ff @(posedge ref_clk_i) begin
		mode_q <= reset_n_i ? mode_d : 3'h0;
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	property p_normal; mode_q inside {3'h0, 3'h1} |=> pins == 5'h1E; endproperty
	a_normal: assert property (p_normal) else $error("normal pins wrong");
	property p_basic; mode_q == 3'h2 |=> pins == 5'h18; endproperty
	a_basic: assert property (p_basic) else $error("basic pins wrong");
	property p_rclk; mode_q == 3'h3 |=> pins == 5'h1C; endproperty
	a_rclk: assert property (p_rclk) else $error("clock loop pins wrong");
	property p_rdat; mode_q == 3'h4 |=> pins == 5'h1A; endproperty
	a_rdat: assert property (p_rdat) else $error("data loop pins wrong");
	property p_bypass; mode_q == 3'h5 |=> pins == 5'h0E; endproperty
	a_bypass: assert property (p_bypass) else $error("bypass pins wrong");
	property p_refsel; ref_sel_bypass_o == (mode_q == 3'h5); endproperty
	a_refsel: assert property (p_refsel) else $error("bypass reference select wrong");
	property p_local; mode_q == 3'h6 |=> pins == 5'h16; endproperty
	a_local: assert property (p_local) else $error("local pins wrong");
	property p_rate; wr |=> rate == $past(pwdata_i[8:5]); endproperty
	a_rate: assert property (p_rate) else $error("rate pins wrong");
	property p_txfall; $changed(tx_par_data_o) |-> $fell(tx_par_clk_o); endproperty
	a_txfall: assert property (p_txfall) else $error("tx word off clock");
	c_basic: cover property (mode_q == 3'h2);
	c_tx: cover property ($fell(tx_par_clk_o));
	c_wr: cover property (wr);
endmodule

// [tb/spmc_dev_model.sv]
// Purpose: behavioural device at the parallel pins
// Assumes: receive clock runs free at 48 ns
// Notes: local loopback returns the last transmit word
`timescale 1ns/1ns
module spmc_dev_model (
	input  wire logic       tx_par_clk_i,   // tx clock
	input  wire logic [3:0] tx_par_data_i,  // tx word
	input  wire logic       rx_path_sel0_i, // path select
	input  wire logic       rx_path_sel1_i, // path select
	output logic            rx_par_clk_o,   // rx clock
	output logic      [3:0] rx_par_data_o   // rx word
);
	logic [3:0] cnt = 4'h0;
	logic [3:0] lb = 4'h0;
	initial begin
		rx_par_clk_o = 1'b0;
		#7;
		forever #24 rx_par_clk_o = ~rx_par_clk_o;
	end
	// msb goes out first and lands back in the msb lane
	always @(posedge tx_par_clk_i) begin
		lb <= tx_par_data_i;
	end
	always @(negedge rx_par_clk_o) begin
		cnt <= cnt + 4'h1;
	end
	assign rx_par_data_o = (rx_path_sel0_i && !rx_path_sel1_i) ? lb : cnt;
endmodule

// [tb/tb_top.sv]
// Purpose: self-checking bench for the serdes path and mode controller
// Assumes: device model on the parallel side
// Notes: pattern memory is written before transmit starts
`timescale 1ns/1ns
module tb_top;
	logic        ref_clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic [7:0]  paddr_i   = 8'h00;
	logic        psel_i    = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i  = 1'b0;
	logic [31:0] pwdata_i  = 32'h0;
	logic [31:0] rd;
	logic        er;
	logic [15:0] c1;
	wire  [31:0] prdata_o;
	wire         pready_o, pslverr_o, rx_clk, tx_clk, osc, bp;
	wire  [3:0]  rx_dat, tx_dat, rate;
	wire  [4:0]  pins;
	int          fails = 0;
	int          compares = 0;
	int          cyc = 0;
	logic [3:0]  pat [4] = '{4'h9, 4'h6, 4'hA, 4'h3};
	logic [4:0]  tbl [7] = '{5'h1E, 5'h1E, 5'h18, 5'h1C, 5'h1A, 5'h0E, 5'h16};
	spmc_ctrl spmc_ctrl_i (
		.ref_clk_i, .reset_n_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .rx_par_clk_i(rx_clk), .rx_par_data_i(rx_dat),
		.tx_par_clk_o(tx_clk), .tx_par_data_o(tx_dat), .rx_path_sel0_o(pins[4]),
		.rx_path_sel1_o(pins[3]), .tx_path_sel0_o(pins[2]), .tx_path_sel1_o(pins[1]),
		.rx_double_rate_sel_o(pins[0]), .rx_rate_sel0_o(rate[3]), .rx_rate_sel1_o(rate[2]),
		.tx_rate_sel0_o(rate[1]), .tx_rate_sel1_o(rate[0]), .ref_osc_en_o(osc),
		.ref_sel_bypass_o(bp)
	);
	spmc_dev_model spmc_dev_model_i (
		.tx_par_clk_i(tx_clk), .tx_par_data_i(tx_dat), .rx_path_sel0_i(pins[4]),
		.rx_path_sel1_i(pins[3]), .rx_par_clk_o(rx_clk), .rx_par_data_o(rx_dat)
	);
	task automatic end_sim();
		if (fails == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("Error %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		// one idle edge between calls, so psel is never driven twice in one step
		@(posedge ref_clk_i);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= w;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge ref_clk_i);
		penable_i <= 1'b1;
		do @(posedge ref_clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic do_reset();
		reset_n_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
	endtask
	initial begin
		forever #20 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			end_sim();
		end
	end
	initial begin
		do_reset();
		chk("pins", 32'(pins), 32'h1E);
		apb(1'b0, spmc_pkg::OFF_CTRL, 32'h0);
		chk("ctrl", rd, 32'h160);
		chk("rate", 32'(rate), 32'hD);
		chk("osc", 32'(osc), 32'h1);
		apb(1'b0, spmc_pkg::OFF_PATLEN, 32'h0);
		chk("patlen", rd, 32'hF);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, spmc_pkg::OFF_PATWR, 32'(i * 16) | 32'(pat[i]));
		end
		apb(1'b1, spmc_pkg::OFF_PATLEN, 32'h3);
		for (int m = 0; m < 7; m++) begin
			apb(1'b1, spmc_pkg::OFF_CTRL, 32'h160 | 32'(m * 2));
			repeat (2) @(posedge ref_clk_i);
			chk("pins", 32'(pins), 32'(tbl[m]));
			chk("bypass", 32'(bp), 32'(m == 5));
		end
		// mode code 7 is refused while the rate field still lands
		apb(1'b1, spmc_pkg::OFF_CTRL, 32'hAE);
		apb(1'b0, spmc_pkg::OFF_CTRL, 32'h0);
		chk("ctrl", rd, 32'hAC);
		chk("rate", 32'(rate), 32'hA);
		chk("pins", 32'(pins), 32'h16);
		apb(1'b0, 8'h10, 32'h0);
		chk("slverr", 32'(er), 32'h1);
		chk("unmapped", rd, 32'h0);
		apb(1'b1, spmc_pkg::OFF_CTRL, 32'h16D);
		for (int k = 0; k < 8; k++) begin
			@(negedge tx_clk);
			@(posedge ref_clk_i);
			chk("txword", 32'(tx_dat), 32'(pat[k % 4]));
		end
		apb(1'b0, spmc_pkg::OFF_STATUS, 32'h0);
		c1 = rd[31:16];
		apb(1'b1, spmc_pkg::OFF_CTRL, 32'h16C);
		apb(1'b1, spmc_pkg::OFF_PATLEN, 32'h0);
		apb(1'b1, spmc_pkg::OFF_CTRL, 32'h16D);
		repeat (100) @(posedge ref_clk_i);
		apb(1'b0, spmc_pkg::OFF_STATUS, 32'h0);
		chk("rxword", 32'(rd[3:0]), 32'h9);
		chk("rxcnt", 32'(rd[31:16] != c1), 32'h1);
		apb(1'b1, spmc_pkg::OFF_CTRL, 32'h163);
		repeat (3) @(posedge ref_clk_i);
		repeat (6) begin
			@(posedge ref_clk_i);
			chk("txclk", 32'(tx_clk), 32'h0);
		end
		apb(1'b1, spmc_pkg::OFF_CTRL, 32'h164);
		do_reset();
		chk("pins", 32'(pins), 32'h1E);
		chk("osc", 32'(osc), 32'h0);
		apb(1'b0, spmc_pkg::OFF_CTRL, 32'h0);
		chk("ctrl", rd, 32'h160);
		end_sim();
	end
endmodule
bind spmc_ctrl spmc_chk spmc_chk_i (
	.ref_clk_i, .reset_n_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
	.tx_par_clk_o, .tx_par_data_o, .rx_path_sel0_o, .rx_path_sel1_o, .tx_path_sel0_o,
	.tx_path_sel1_o, .rx_double_rate_sel_o, .rx_rate_sel0_o, .rx_rate_sel1_o,
	.tx_rate_sel0_o, .tx_rate_sel1_o, .ref_sel_bypass_o
);
